// >>> core/link_pkg.sv
// Shared constants for the 21-bit serial link transmitter and receiver
package link_pkg;

  // Word and lane geometry
  localparam int WORD_W    = 21;  // Parallel word width
  localparam int LANES     = 3;   // Serial data lanes
  localparam int SLOTS     = 7;   // Bit slots per forwarded clock period
  localparam int SLOT_W    = 3;   // Width of a slot counter
  localparam logic [SLOT_W-1:0] SLOT_FIRST = 3'h0;
  localparam logic [SLOT_W-1:0] SLOT_LAST  = 3'h6;
  localparam logic [SLOT_W-1:0] SLOT_STEP  = 3'h1;

  // Forwarded clock is high during the first slots of a period, then low
  localparam logic [SLOT_W-1:0] CLK_HIGH_SLOTS = 3'h4;

  // System clock rate and clock multiplier settle time
  localparam int CLK_HZ        = 10_000_000;
  localparam int SETTLE_MS     = 10;
  localparam int SETTLE_CYCLES = (SETTLE_MS * CLK_HZ + 999) / 1000;
  localparam int SETTLE_W      = 24;  // Width of the settle counter

  // Receive strobe stays low three cycles after new data appears, as the timer counts STROBE_LOW_LAST down to zero
  localparam int STROBE_W = 2;
  localparam logic [STROBE_W-1:0] STROBE_LOW_LAST = 2'h2;
  localparam logic [STROBE_W-1:0] STROBE_ZERO     = 2'h0;
  localparam logic [STROBE_W-1:0] STROBE_STEP     = 2'h1;

  // Two-entry word buffer in the transmit path
  localparam int BUF_DEPTH = 2;
  localparam logic [1:0] BUF_FULL  = 2'h2;
  localparam logic [1:0] BUF_EMPTY = 2'h0;
  localparam logic [1:0] BUF_ONE   = 2'h1;

  // Synchronised input vector width
  localparam int SYNC_W = WORD_W + LANES + 4;

  // Transmitter power states
  typedef enum logic [1:0] {TX_OFF, TX_SETTLE, TX_RUN} tx_state_t;

endpackage

// >>> core/serial_link.sv
// 21-bit parallel to three-lane serial link, transmitter and receiver halves
// Overview of operation
// - Capture parallel word on strobe rising edge only
// - Power-down floats all lanes and forwarded clock
// - Receiver power-down drives parallel outputs low
// - Output data aligned to receive strobe rising edge
// - Three data lanes plus one forwarded clock
// - Rebuild 21 output bits from three lanes
// - Seven bit slots per forwarded clock period
// - No toggling until settle time after release
// - Stopped clock: strobe stops, data holds
`timescale 1ns/1ps
module serial_link
  import link_pkg::*;
#(
  parameter int SETTLE = SETTLE_CYCLES  // Clock multiplier settle count
) (
  // Clock and reset
  input  wire logic              clk,
  input  wire logic              nrst,
  // Transmit parallel side
  input  wire logic [WORD_W-1:0] parallel_data_in,
  input  wire logic              tx_strobe_clock_in,
  input  wire logic              tx_power_down_n,
  output logic                   tx_ready,
  // Transmit serial link
  output logic [LANES-1:0]       serial_lane_out,
  output logic                   serial_lane_oe,
  output logic                   forwarded_clock_out,
  output logic                   forwarded_clock_oe,
  // Receive serial link
  input  wire logic [LANES-1:0]  serial_lane_in,
  input  wire logic              forwarded_clock_in,
  // Receive parallel side
  input  wire logic              rx_power_down_n,
  output logic [WORD_W-1:0]      parallel_data_out,
  output logic                   rx_strobe_clock_out
);

  // Synchroniser stages for every pin input
  logic [SYNC_W-1:0] sync_a;       // First stage, read only by sync_b
  logic [SYNC_W-1:0] sync_b;       // Second stage, safe to use
  logic [SYNC_W-1:0] raw_in;       // Gathered pin inputs
  assign raw_in = {parallel_data_in, serial_lane_in, forwarded_clock_in,
                   rx_power_down_n, tx_power_down_n, tx_strobe_clock_in};

  // Two flip-flops per input bit
  for (genvar i = 0; i < SYNC_W; i++) begin : g_sync
    always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
        sync_a[i] <= 1'b0;
        sync_b[i] <= 1'b0;
      end else begin
        sync_a[i] <= raw_in[i];
        sync_b[i] <= sync_a[i];
      end
    end
  end

  // Named views of the synchronised inputs
  logic              strobe_s;     // Transmit strobe clock
  logic              tx_pd_n_s;    // Transmit power-down, active low
  logic              rx_pd_n_s;    // Receive power-down, active low
  logic              fclk_s;       // Incoming forwarded clock
  logic [LANES-1:0]  lane_s;       // Incoming serial lanes
  logic [WORD_W-1:0] pdata_s;      // Parallel input word
  assign strobe_s  = sync_b[0];
  assign tx_pd_n_s = sync_b[1];
  assign rx_pd_n_s = sync_b[2];
  assign fclk_s    = sync_b[3];
  assign lane_s    = sync_b[3+LANES:4];
  assign pdata_s   = sync_b[SYNC_W-1:4+LANES];

  // Previous values for edge detection
  logic strobe_prev;               // Strobe one cycle ago
  logic fclk_prev;                 // Forwarded clock one cycle ago
  logic strobe_rise;               // Strobe rising edge seen
  logic fclk_rise;                 // Forwarded clock rising edge seen
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      strobe_prev <= 1'b0;
      fclk_prev   <= 1'b0;
    end else begin
      strobe_prev <= strobe_s;
      fclk_prev   <= fclk_s;
    end
  end
  assign strobe_rise = strobe_s && !strobe_prev;
  assign fclk_rise   = fclk_s && !fclk_prev;

  // Transmit state
  tx_state_t             tx_state, next_tx_state;       // Power state
  logic [SETTLE_W-1:0]   settle_cnt, next_settle_cnt;   // Settle timer
  logic [WORD_W-1:0]     buf_mem [BUF_DEPTH];           // Word buffer
  logic [WORD_W-1:0]     next_buf_mem [BUF_DEPTH];
  logic                  wr_ptr, next_wr_ptr;           // Buffer write slot
  logic                  rd_ptr, next_rd_ptr;           // Buffer read slot
  logic [1:0]            buf_count, next_buf_count;     // Words held
  logic                  ser_busy, next_ser_busy;       // Serialiser running
  logic [WORD_W-1:0]     ser_word, next_ser_word;       // Word being sent
  logic [SLOT_W-1:0]     ser_slot, next_ser_slot;       // Current slot
  logic [LANES-1:0]      next_lane_out;
  logic                  next_fclk_out;
  logic                  next_oe;
  logic                  push;                          // Buffer fill
  logic                  pop;                           // Buffer drain

  // Buffer ready faces the parallel side
  assign tx_ready = (buf_count != BUF_FULL);

  // Transmit next-state logic
  always_comb begin
    next_tx_state   = tx_state;
    next_settle_cnt = settle_cnt;
    next_buf_mem    = buf_mem;
    next_wr_ptr     = wr_ptr;
    next_rd_ptr     = rd_ptr;
    next_buf_count  = buf_count;
    next_ser_busy   = ser_busy;
    next_ser_word   = ser_word;
    next_ser_slot   = ser_slot;
    push = 1'b0;
    pop  = 1'b0;
    // Power state sequencing
    unique case (tx_state)
      TX_OFF: begin
        next_settle_cnt = '0;
        if (tx_pd_n_s) begin
          next_tx_state = TX_SETTLE;
        end
      end
      TX_SETTLE: begin
        // Hold outputs quiet until the multiplier has settled
        next_settle_cnt = settle_cnt + 1'b1;
        if (settle_cnt == SETTLE_W'(SETTLE - 1)) begin
          next_tx_state = TX_RUN;
        end
      end
      TX_RUN: begin
        // Only the rising edge loads a word
        push = strobe_rise && tx_ready;
        // Serialiser takes a word when idle or finishing its last slot
        pop = (buf_count != BUF_EMPTY) && (!ser_busy || ser_slot == SLOT_LAST);
      end
    endcase
    // Serialiser slot sequencing
    if (pop) begin
      next_ser_busy = 1'b1;
      next_ser_word = buf_mem[rd_ptr];
      next_ser_slot = SLOT_FIRST;
      next_rd_ptr   = !rd_ptr;
    end else if (ser_busy && ser_slot == SLOT_LAST) begin
      next_ser_busy = 1'b0;
      next_ser_slot = SLOT_FIRST;
    end else if (ser_busy) begin
      next_ser_slot = ser_slot + SLOT_STEP;
    end
    // Buffer write
    if (push) begin
      next_buf_mem[wr_ptr] = pdata_s;
      next_wr_ptr          = !wr_ptr;
    end
    // Occupancy
    if (push && !pop) begin
      next_buf_count = buf_count + BUF_ONE;
    end else if (pop && !push) begin
      next_buf_count = buf_count - BUF_ONE;
    end
    // Power-down flushes everything
    if (!tx_pd_n_s) begin
      next_tx_state  = TX_OFF;
      next_wr_ptr    = 1'b0;
      next_rd_ptr    = 1'b0;
      next_buf_count = BUF_EMPTY;
      next_ser_busy  = 1'b0;
      next_ser_slot  = SLOT_FIRST;
    end
    // Lane k slot s carries word bit k*SLOTS+s
    for (int k = 0; k < LANES; k++) begin
      next_lane_out[k] = ser_busy && ser_word[k*SLOTS + int'(ser_slot)];
    end
    // Forwarded clock high for the first slots of each period
    next_fclk_out = ser_busy && (ser_slot < CLK_HIGH_SLOTS);
    // Drive the pairs unless powered down
    next_oe = (next_tx_state != TX_OFF);
  end

  // Transmit registers
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      tx_state            <= TX_OFF;
      settle_cnt          <= '0;
      buf_mem             <= '{default: '0};
      wr_ptr              <= 1'b0;
      rd_ptr              <= 1'b0;
      buf_count           <= BUF_EMPTY;
      ser_busy            <= 1'b0;
      ser_word            <= '0;
      ser_slot            <= SLOT_FIRST;
      serial_lane_out     <= '0;
      forwarded_clock_out <= 1'b0;
      serial_lane_oe      <= 1'b0;
      forwarded_clock_oe  <= 1'b0;
    end else begin
      tx_state            <= next_tx_state;
      settle_cnt          <= next_settle_cnt;
      buf_mem             <= next_buf_mem;
      wr_ptr              <= next_wr_ptr;
      rd_ptr              <= next_rd_ptr;
      buf_count           <= next_buf_count;
      ser_busy            <= next_ser_busy;
      ser_word            <= next_ser_word;
      ser_slot            <= next_ser_slot;
      serial_lane_out     <= next_lane_out;
      forwarded_clock_out <= next_fclk_out;
      serial_lane_oe      <= next_oe;
      forwarded_clock_oe  <= next_oe;
    end
  end

  // Receive state
  logic                rx_active, next_rx_active;    // Collecting slots
  logic [SLOT_W-1:0]   rx_slot, next_rx_slot;        // Slot being sampled
  logic [WORD_W-1:0]   rx_acc, next_rx_acc;          // Word being rebuilt
  logic [WORD_W-1:0]   next_pdata_out;
  logic                next_strobe_out;
  logic                strobe_pend, next_strobe_pend; // Strobe rise pending
  logic [STROBE_W-1:0] strobe_cnt, next_strobe_cnt;  // Low-phase timer
  logic                word_done;                    // Last slot this cycle

  assign word_done = rx_active && (rx_slot == SLOT_LAST);

  // Receive next-state logic
  always_comb begin
    next_rx_active   = rx_active;
    next_rx_slot     = rx_slot;
    next_rx_acc      = rx_acc;
    next_pdata_out   = parallel_data_out;
    next_strobe_out  = rx_strobe_clock_out;
    next_strobe_pend = strobe_pend;
    next_strobe_cnt  = strobe_cnt;
    // A clock rise samples slot zero at once, so slot one is the next to take
    if (fclk_rise) begin
      next_rx_active = 1'b1;
      next_rx_slot   = SLOT_FIRST + SLOT_STEP;
    end
    // Sample every lane in the current slot
    if (fclk_rise || rx_active) begin
      for (int k = 0; k < LANES; k++) begin
        next_rx_acc[k*SLOTS + int'(fclk_rise ? SLOT_FIRST : rx_slot)] = lane_s[k];
      end
    end
    if (!fclk_rise && rx_active) begin
      next_rx_slot = rx_slot + SLOT_STEP;
    end
    // Present the rebuilt word with the strobe low, then raise it
    if (!fclk_rise && word_done) begin
      next_rx_active   = 1'b0;
      next_pdata_out   = next_rx_acc;
      next_strobe_out  = 1'b0;
      next_strobe_pend = 1'b1;
      next_strobe_cnt  = STROBE_LOW_LAST;
    end else if (strobe_pend && strobe_cnt == STROBE_ZERO) begin
      next_strobe_out  = 1'b1;
      next_strobe_pend = 1'b0;
    end else if (strobe_pend) begin
      next_strobe_cnt = strobe_cnt - STROBE_STEP;
    end
    // Without words the strobe and data simply stay put
    // Power-down forces outputs low
    if (!rx_pd_n_s) begin
      next_rx_active   = 1'b0;
      next_pdata_out   = '0;
      next_strobe_out  = 1'b0;
      next_strobe_pend = 1'b0;
    end
  end

  // Receive registers
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rx_active           <= 1'b0;
      rx_slot             <= SLOT_FIRST;
      rx_acc              <= '0;
      parallel_data_out   <= '0;
      rx_strobe_clock_out <= 1'b0;
      strobe_pend         <= 1'b0;
      strobe_cnt          <= STROBE_ZERO;
    end else begin
      rx_active           <= next_rx_active;
      rx_slot             <= next_rx_slot;
      rx_acc              <= next_rx_acc;
      parallel_data_out   <= next_pdata_out;
      rx_strobe_clock_out <= next_strobe_out;
      strobe_pend         <= next_strobe_pend;
      strobe_cnt          <= next_strobe_cnt;
    end
  end

  // Checks
  logic tx_bit0;  // Bit that lane zero should carry
  assign tx_bit0 = ser_word[int'(ser_slot)];

  property p_tx_hiz;
    @(posedge clk) disable iff (!nrst) !tx_pd_n_s |=> !serial_lane_oe && !forwarded_clock_oe;
  endproperty
  a_tx_hiz: assert property (p_tx_hiz) else $error("lanes driven in power-down");

  property p_rx_low;
    @(posedge clk) disable iff (!nrst) !rx_pd_n_s |=> parallel_data_out == '0 && !rx_strobe_clock_out;
  endproperty
  a_rx_low: assert property (p_rx_low) else $error("receiver outputs not low in power-down");

  property p_push_rise;
    @(posedge clk) disable iff (!nrst) (tx_state == TX_RUN && tx_pd_n_s && !strobe_rise) |=> $stable(wr_ptr);
  endproperty
  a_push_rise: assert property (p_push_rise) else $error("word taken without rising strobe");

  property p_settle;
    @(posedge clk) disable iff (!nrst) $rose(tx_state == TX_RUN) |-> $past(settle_cnt) == SETTLE_W'(SETTLE - 1);
  endproperty
  a_settle: assert property (p_settle) else $error("run entered before settle time");

  property p_quiet;
    @(posedge clk) disable iff (!nrst) tx_state != TX_RUN |=> !forwarded_clock_out && serial_lane_out == '0;
  endproperty
  a_quiet: assert property (p_quiet) else $error("link toggled before settle");

  property p_slot_step;
    @(posedge clk) disable iff (!nrst)
      (ser_busy && tx_pd_n_s && ser_slot != SLOT_LAST) |=> ser_busy && ser_slot == $past(ser_slot) + SLOT_STEP;
  endproperty
  a_slot_step: assert property (p_slot_step) else $error("slot sequence broken");

  property p_fclk_shape;
    @(posedge clk) disable iff (!nrst) ser_busy |=> forwarded_clock_out == ($past(ser_slot) < CLK_HIGH_SLOTS);
  endproperty
  a_fclk_shape: assert property (p_fclk_shape) else $error("forwarded clock shape wrong");

  property p_lane_map;
    @(posedge clk) disable iff (!nrst) ser_busy |=> serial_lane_out[0] == $past(tx_bit0);
  endproperty
  a_lane_map: assert property (p_lane_map) else $error("lane zero bit mapping wrong");

  property p_strobe;
    @(posedge clk) disable iff (!nrst)
      (word_done && !fclk_rise && rx_pd_n_s) ##1 rx_pd_n_s [*4] |-> $past(!rx_strobe_clock_out, 2) && rx_strobe_clock_out;
  endproperty
  a_strobe: assert property (p_strobe) else $error("receive strobe timing wrong");

  property p_hold;
    @(posedge clk) disable iff (!nrst) (rx_pd_n_s && !word_done) |=> $stable(parallel_data_out);
  endproperty
  a_hold: assert property (p_hold) else $error("receive data changed without a word");

  c_word_out: cover property (@(posedge clk) disable iff (!nrst) word_done && rx_pd_n_s);
  c_back2back: cover property (@(posedge clk) disable iff (!nrst) pop && ser_busy);
  c_buf_full: cover property (@(posedge clk) disable iff (!nrst) buf_count == BUF_FULL);
  c_rx_pd: cover property (@(posedge clk) disable iff (!nrst) $fell(rx_pd_n_s));

endmodule

// >>> sim/link_partner.sv
// Far-side model: decodes the transmit lanes and drives the receive lanes
`timescale 1ns/1ps
module link_partner
  import link_pkg::*;
(
  // Clock
  input  wire logic             clk,
  // Transmit lanes from the design
  input  wire logic [LANES-1:0] tx_lanes,
  input  wire logic             tx_fclk,
  input  wire logic             tx_oe,
  // Receive lanes into the design
  output logic      [LANES-1:0] rx_lanes,
  output logic                  rx_fclk
);
  logic [WORD_W-1:0] got_q[$];  // Words decoded off the lanes
  logic [WORD_W-1:0] shift;     // Word being decoded
  logic              prev_fclk; // Driven forwarded clock, last sample
  int                slot;      // Slot being decoded, -1 when idle
  bit                sending;   // A receive frame is on the lanes

  // Idle values at time zero
  initial begin
    rx_lanes  = 3'h0;
    rx_fclk   = 1'h0;
    prev_fclk = 1'h0;
    shift     = '0;
    slot      = -1;
  end

  // Decode at the falling edge, where registered lanes have settled
  always @(negedge clk) begin
    // A floated link cuts any frame in progress
    if (!tx_oe) slot = -1;
    if (tx_oe && tx_fclk && !prev_fclk) slot = 0;
    if (slot >= 0) begin
      for (int k = 0; k < LANES; k++) shift[k*SLOTS+slot] = tx_lanes[k];
      slot = (slot == SLOTS - 1) ? -1 : slot + 1;
      if (slot < 0) got_q.push_back(shift);
    end
    prev_fclk = tx_fclk && tx_oe;
    // Idle lanes change every cycle so no stale bit can pass for data
    if (!sending) rx_lanes <= ~rx_lanes;
  end

  // One frame: seven slots plus one idle slot, so the period is eight cycles
  task automatic send(input logic [WORD_W-1:0] w);
    @(posedge clk);
    sending = 1'h1;
    for (int s = 0; s <= SLOTS; s++) begin
      @(negedge clk);
      rx_fclk <= (s < CLK_HIGH_SLOTS);
      for (int k = 0; k < LANES; k++) rx_lanes[k] <= (s < SLOTS) ? w[k*SLOTS+s] : ~rx_lanes[k];
    end
    @(posedge clk);
    sending = 1'h0;  // Clock now stands still low
  endtask
endmodule

// >>> sim/tb.sv
// Self-checking bench for the serial link: transmit, buffer, power-down, receive
`timescale 1ns/1ps
module tb
  import link_pkg::*;
;
  localparam int SET = 20;             // Shortened settle count
  logic              clk = 1'h0;       // System clock
  logic              nrst = 1'h0;      // Reset, active low
  logic [WORD_W-1:0] parallel_data_in = '0;
  logic              tx_strobe_clock_in = 1'h0;
  logic              tx_power_down_n = 1'h1;
  logic              rx_power_down_n = 1'h1;
  logic              tx_ready, serial_lane_oe, forwarded_clock_out, forwarded_clock_oe, rx_strobe_clock_out;
  logic [LANES-1:0]  serial_lane_out, serial_lane_in;
  logic              forwarded_clock_in;
  logic [WORD_W-1:0] parallel_data_out;
  int                n_fail = 0;       // Mismatches
  int                checks_done = 0;  // Comparisons
  int                cyc = 0;          // Cycle count for the timeout
  bit                saw_full = 0;     // Ready seen low
  logic [WORD_W-1:0] w;                // Current word
  logic [WORD_W-1:0] burst[4];         // Burst words

  // 10 MHz clock
  always #50 clk = ~clk;

  serial_link #(.SETTLE(SET)) serial_link_i (
    .clk(clk), .nrst(nrst), .parallel_data_in(parallel_data_in), .tx_strobe_clock_in(tx_strobe_clock_in),
    .tx_power_down_n(tx_power_down_n), .tx_ready(tx_ready), .serial_lane_out(serial_lane_out),
    .serial_lane_oe(serial_lane_oe), .forwarded_clock_out(forwarded_clock_out),
    .forwarded_clock_oe(forwarded_clock_oe), .serial_lane_in(serial_lane_in),
    .forwarded_clock_in(forwarded_clock_in), .rx_power_down_n(rx_power_down_n),
    .parallel_data_out(parallel_data_out), .rx_strobe_clock_out(rx_strobe_clock_out));

  link_partner link_partner_i (
    .clk(clk), .tx_lanes(serial_lane_out), .tx_fclk(forwarded_clock_out), .tx_oe(forwarded_clock_oe),
    .rx_lanes(serial_lane_in), .rx_fclk(forwarded_clock_in));

  // Timeout and buffer-full watch
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (tx_ready === 1'h0) saw_full <= 1'h1;
    if (cyc == 5000) begin
      n_fail++;
      tally_and_finish();
    end
  end

  // Verdict and end of run
  task automatic tally_and_finish();
    if (n_fail == 0 && checks_done > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  // Compare one value and report a mismatch
  task automatic check(input logic [WORD_W-1:0] got, input logic [WORD_W-1:0] exp, input string what);
    checks_done++;
    if (got !== exp) begin
      n_fail++;
      $display("unexpected at %0t ns: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  // Word on rise; data flips at the falling edge, which must not capture it
  task automatic strobe(input logic [WORD_W-1:0] d, input int hi, input int lo);
    @(negedge clk);
    parallel_data_in = d;
    tx_strobe_clock_in = 1'h1;
    repeat (hi) @(negedge clk);
    parallel_data_in = ~d;
    tx_strobe_clock_in = 1'h0;
    repeat (lo) @(negedge clk);
  endtask

  // Wait, bounded, for a decoded word and compare it
  task automatic expect_word(input logic [WORD_W-1:0] exp);
    int n;
    n = 0;
    while (link_partner_i.got_q.size() == 0 && n < 60) begin
      @(negedge clk);
      n++;
    end
    if (link_partner_i.got_q.size() == 0) check(21'h0, 21'h1, "no word on the lanes");
    else check(link_partner_i.got_q.pop_front(), exp, "lane word");
  endtask

  // Send one frame in and compare the word once the strobe rises
  task automatic rx_word(input logic [WORD_W-1:0] d);
    int n;
    n = 0;
    link_partner_i.send(d);
    while (rx_strobe_clock_out !== 1'h0 && n < 20) begin
      @(negedge clk);
      n++;
    end
    while (rx_strobe_clock_out !== 1'h1 && n < 30) begin
      @(negedge clk);
      n++;
    end
    check(21'(rx_strobe_clock_out), 21'h1, "receive strobe never rose");
    check(parallel_data_out, d, "receive word");
  endtask

  // Main sequence
  initial begin
    void'($urandom(32'h728B));
    repeat (3) @(negedge clk);
    nrst = 1'h1;
    // Settle: a strobed word is dropped and the clock stays quiet
    strobe(21'h0A5A5A, 4, 4);
    repeat (SET - 10) begin
      @(negedge clk);
      check(21'(forwarded_clock_out), 21'h0, "clock during settle");
    end
    repeat (20) @(negedge clk);
    check(21'(link_partner_i.got_q.size()), 21'h0, "word kept from settle");
    // Words with corner values, then random
    for (int i = 0; i < 8; i++) begin
      w = (i == 0) ? 21'h0 : (i == 1) ? 21'h1FFFFF : WORD_W'($urandom);
      strobe(w, 5, 5);
      expect_word(w);
    end
    // Burst every two cycles: serialiser plus two entries, fourth dropped
    saw_full = 1'h0;
    for (int i = 0; i < 4; i++) begin
      burst[i] = WORD_W'($urandom);
      strobe(burst[i], 1, 0);
    end
    for (int i = 0; i < 3; i++) expect_word(burst[i]);
    repeat (20) @(negedge clk);
    check(21'(link_partner_i.got_q.size()), 21'h0, "word past full buffer");
    check(21'(saw_full), 21'h1, "ready while full");
    // Transmit power-down floats lanes and drops words
    tx_power_down_n = 1'h0;
    repeat (5) @(negedge clk);
    check(21'({serial_lane_oe, forwarded_clock_oe}), 21'h0, "lanes driven in power-down");
    strobe(w, 5, 5);
    tx_power_down_n = 1'h1;
    repeat (SET + 10) @(negedge clk);
    check(21'(link_partner_i.got_q.size()), 21'h0, "word kept from power-down");
    w = WORD_W'($urandom);
    strobe(w, 5, 5);
    expect_word(w);
    // Receive words, then a stopped clock holds everything
    for (int i = 0; i < 6; i++) begin
      w = (i == 0) ? 21'h1FFFFF : WORD_W'($urandom);
      rx_word(w);
    end
    repeat (30) begin
      @(negedge clk);
      check(parallel_data_out, w, "data after clock stop");
      check(21'(rx_strobe_clock_out), 21'h1, "strobe after clock stop");
    end
    // Receive power-down forces outputs low
    rx_power_down_n = 1'h0;
    repeat (5) @(negedge clk);
    check(parallel_data_out, 21'h0, "outputs in power-down");
    check(21'(rx_strobe_clock_out), 21'h0, "strobe in power-down");
    rx_power_down_n = 1'h1;
    repeat (3) @(negedge clk);
    w = WORD_W'($urandom);
    rx_word(w);
    tally_and_finish();
  end
endmodule
